// *** tmpc_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the timer control block.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef TMPC_CFG_SVH
`define TMPC_CFG_SVH
// -----------------------------------------------------------------
// Register indices and byte addresses
// -----------------------------------------------------------------
`define TMPC_CTL0_IDX 12'hF06
`define TMPC_CTL1_IDX 12'hF07
`define TMPC_T1_CTL0_IDX 12'hF0E
`define TMPC_T1_CTL1_IDX 12'hF0F
`define TMPC_RELOAD_ADDR 16'h0000
`define TMPC_CMP_ADDR 16'h0004
`define TMPC_CNT_ADDR 16'h0008
`define TMPC_CAP_ADDR 16'h000C
`define TMPC_STS_ADDR 16'h0010
`define TMPC_MSK_ADDR 16'h0014
`define TMPC_FN_ADDR 16'h0018
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define TMPC_EN_BIT 7
`define TMPC_POL_BIT 6
`define TMPC_PRESCALE_EXPONENT_HI 5
`define TMPC_PRESCALE_EXPONENT_LO 3
`define TMPC_MODE_HI 2
`define TMPC_MODEHI_BIT 7
`define TMPC_ICFG_HI 6
`define TMPC_ICFG_LO 5
`define TMPC_RSVD_BIT 4
`define TMPC_DB_HI 3
`define TMPC_DB_LO 1
`define TMPC_INPCAP_BIT 0
`define TMPC_ST_RELOAD 0
`define TMPC_ST_CAPT 1
`define TMPC_ST_MATCH 2
`define TMPC_ST_GATE 3
// -----------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------
`define TMPC_CTL_RST 8'h00
`define TMPC_CNT_START 16'h0001
`define TMPC_ICFG_INPUT 2'h2
`define TMPC_ICFG_RELOAD 2'h3
`define TMPC_DB_SAT 8'hFF
`endif

// *** tmpc_pkg.sv ***
// Purpose: Types shared by the timer control block.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Constants live in tmpc_cfg.svh.
package tmpc_pkg;
  typedef enum logic [3:0] {
    ONE_SHOT, CONTINUOUS, COUNTER, PWM_SINGLE, CAPTURE, COMPARE, GATED,
    CAPTURE_COMPARE, PWM_DUAL, CAPTURE_RESTART, COMPARATOR_COUNTER,
    RSVD_B, RSVD_C, RSVD_D, RSVD_E, RSVD_F
  } tmpc_mode_e;
  typedef struct packed {
    logic [6:0] cnt;
  } tmpc_pre_s;
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic fn_en;
    logic [15:0] reload;
    logic [15:0] cmp;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [3:0] sts;
    logic [3:0] msk;
    logic tin;
    logic started;
    logic ideal;
    logic [7:0] dcnt;
    logic out;
    logic outc;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic ready;
  } tmpc_state_s;
endpackage

// *** tmpc_prescale.sv ***
// Purpose: Power-of-two prescaler giving a one-cycle count enable.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Clear holds the divider at zero.
`timescale 1ns/1ps
`include "tmpc_cfg.svh"
module tmpc_prescale #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic clr,
  input wire logic [2:0] exp_sel,
  // Enable pulse
  output logic tick
);
  tmpc_pkg::tmpc_pre_s s_q;
  tmpc_pkg::tmpc_pre_s s_d;
  logic [W:0] full;
  logic [W-1:0] mask;

  // -----------------------------------------------------------------
  // Divider
  // -----------------------------------------------------------------
  always_comb begin
    full = ({{W{1'b0}}, 1'b1} << exp_sel) - {{W{1'b0}}, 1'b1};
    mask = full[W-1:0];
    tick = !clr && ((s_q.cnt & mask) == mask);
    s_d = s_q;
    s_d.cnt = clr ? '0 : s_q.cnt + 7'h01;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  clr_zero_a: assert property (@(posedge clk) disable iff (!rst_b) clr |=> s_q.cnt == 7'h00)
    else $error("Prescaler not cleared.");
endmodule // tmpc_prescale

// *** tmpc_top.sv ***
// Purpose: One counter/timer with mode, polarity, prescale and dead-band control over AHB-Lite.
// Assumes: Pins synchronous to CLK; one slave on the bus, so HREADY is its own HREADYOUT.
// Notes: Writes take no wait state, reads take one.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "tmpc_cfg.svh"
module tmpc_top #(
  parameter logic [11:0] CTL0_IDX = `TMPC_CTL0_IDX,
  parameter logic [11:0] CTL1_IDX = `TMPC_CTL1_IDX
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [15:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Timer pins
  input wire logic TIN,
  output logic TOUT,
  output logic TOUT_OE,
  output logic TOUTC,
  // Interrupt
  output logic IRQ
);
  localparam logic [15:0] CTL0_ADDR = {2'h0, CTL0_IDX, 2'h0};
  localparam logic [15:0] CTL1_ADDR = {2'h0, CTL1_IDX, 2'h0};
  localparam tmpc_pkg::tmpc_state_s RST_S = '{ready: 1'b1, default: '0};

  tmpc_pkg::tmpc_state_s s_q;
  tmpc_pkg::tmpc_state_s s_d;
  tmpc_pkg::tmpc_mode_e mode;
  logic en;
  logic pol;
  logic tick;
  logic rise;
  logic fall;
  logic sel_edge;
  logic off_edge;
  logic adv;
  logic reload_ev;
  logic match_ev;
  logic cap_ev;
  logic gate_ev;
  logic in_ok;
  logic rl_ok;
  logic [3:0] set;
  logic [3:0] clr;
  logic [7:0] dly;
  logic settled;
  logic [31:0] wdat;
  logic [31:0] rval;
  logic cnt_wr;

  assign HRESP = 1'b0;
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = s_q.ready;
  assign TOUT = s_q.out;
  assign TOUTC = s_q.outc;
  assign TOUT_OE = s_q.fn_en;
  assign IRQ = s_q.irq;
  assign wdat = HWDATA;

  // -----------------------------------------------------------------
  // Prescaler
  // -----------------------------------------------------------------
  tmpc_prescale #(
    .W(7)
  ) u_pre (
    .clk(CLK),
    .rst_b(RST_B),
    .clr(!en),
    .exp_sel(s_q.ctl1[`TMPC_PRESCALE_EXPONENT_HI:`TMPC_PRESCALE_EXPONENT_LO]),
    .tick(tick)
  );

  // -----------------------------------------------------------------
  // Timer and bus next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    mode = tmpc_pkg::tmpc_mode_e'({s_q.ctl0[`TMPC_MODEHI_BIT], s_q.ctl1[`TMPC_MODE_HI:0]});
    en = s_q.ctl1[`TMPC_EN_BIT];
    pol = s_q.ctl1[`TMPC_POL_BIT];
    rise = TIN && !s_q.tin;
    fall = !TIN && s_q.tin;
    sel_edge = pol ? fall : rise;
    off_edge = pol ? rise : fall;
    in_ok = s_q.ctl0[`TMPC_ICFG_HI:`TMPC_ICFG_LO] != `TMPC_ICFG_RELOAD;
    rl_ok = s_q.ctl0[`TMPC_ICFG_HI:`TMPC_ICFG_LO] != `TMPC_ICFG_INPUT;
    s_d.tin = TIN;
    case (mode)
      tmpc_pkg::COUNTER: adv = sel_edge;
      tmpc_pkg::GATED: adv = tick && (TIN ^ pol);
      tmpc_pkg::CAPTURE_COMPARE: adv = tick && s_q.started;
      tmpc_pkg::RSVD_B, tmpc_pkg::RSVD_C, tmpc_pkg::RSVD_D,
      tmpc_pkg::RSVD_E, tmpc_pkg::RSVD_F: adv = 1'b0;
      default: adv = tick;
    endcase
    adv = adv && en;
    reload_ev = adv && (s_q.cnt == s_q.reload);
    match_ev = adv && (s_q.cnt == s_q.cmp);
    cap_ev = 1'b0;
    gate_ev = 1'b0;
    if (adv) begin
      s_d.cnt = reload_ev ? `TMPC_CNT_START : s_q.cnt + 16'h0001;
    end
    if (reload_ev && mode == tmpc_pkg::ONE_SHOT) begin
      s_d.ctl1[`TMPC_EN_BIT] = 1'b0;
    end
    // Input events.
    if (!en) begin
      s_d.started = 1'b0;
    end else begin
      case (mode)
        tmpc_pkg::CAPTURE: cap_ev = sel_edge;
        tmpc_pkg::CAPTURE_RESTART: begin
          cap_ev = sel_edge;
          if (sel_edge) begin
            s_d.cnt = `TMPC_CNT_START;
          end
        end
        tmpc_pkg::CAPTURE_COMPARE: begin
          cap_ev = sel_edge && s_q.started;
          if (sel_edge) begin
            s_d.started = 1'b1;
          end
        end
        tmpc_pkg::GATED: gate_ev = off_edge;
        default: cap_ev = 1'b0;
      endcase
    end
    if (cap_ev) begin
      s_d.cap = s_q.cnt;
    end
    // Output waveform.
    if (!en) begin
      s_d.ideal = pol;
    end else if (reload_ev) begin
      s_d.ideal = pol;
    end else if (match_ev) begin
      s_d.ideal = !pol;
    end
    s_d.dcnt = (s_d.ideal != s_q.ideal) ? 8'h00 :
               (s_q.dcnt == `TMPC_DB_SAT) ? s_q.dcnt : s_q.dcnt + 8'h01;
    dly = (s_q.ctl0[`TMPC_DB_HI:`TMPC_DB_LO] == 3'h0) ? 8'h00 :
          8'(9'h001 << s_q.ctl0[`TMPC_DB_HI:`TMPC_DB_LO]);
    settled = s_q.dcnt >= dly;
    case (mode)
      tmpc_pkg::PWM_SINGLE: begin
        s_d.out = en ? s_q.ideal : pol;
        s_d.outc = !s_d.out;
      end
      tmpc_pkg::PWM_DUAL: begin
        if (!en) begin
          s_d.out = pol;
          s_d.outc = !pol;
        end else begin
          s_d.out = (s_q.ideal != pol && settled) ? !pol : pol;
          s_d.outc = (s_q.ideal == pol && settled) ? !pol : pol;
        end
      end
      default: begin
        if (!en) begin
          s_d.out = pol;
        end else if (reload_ev) begin
          s_d.out = !s_q.out;
        end
        s_d.outc = !s_d.out;
      end
    endcase
    // Status, interrupt and capture flag.
    set = '0;
    set[`TMPC_ST_RELOAD] = reload_ev && rl_ok;
    set[`TMPC_ST_MATCH] = match_ev && rl_ok && mode != tmpc_pkg::PWM_SINGLE && mode != tmpc_pkg::PWM_DUAL;
    set[`TMPC_ST_CAPT] = cap_ev && in_ok;
    set[`TMPC_ST_GATE] = gate_ev && in_ok;
    if (set[`TMPC_ST_CAPT]) begin
      s_d.ctl0[`TMPC_INPCAP_BIT] = 1'b1;
    end else if (|set) begin
      s_d.ctl0[`TMPC_INPCAP_BIT] = 1'b0;
    end
    // Bus write data phase.
    clr = '0;
    cnt_wr = 1'b0;
    if (s_q.wr_pend) begin
      case (s_q.addr)
        CTL0_ADDR: begin
          s_d.ctl0[7:1] = wdat[7:1];
          s_d.ctl0[`TMPC_RSVD_BIT] = 1'b0;
        end
        CTL1_ADDR: s_d.ctl1 = wdat[7:0];
        `TMPC_RELOAD_ADDR: s_d.reload = wdat[15:0];
        `TMPC_CMP_ADDR: s_d.cmp = wdat[15:0];
        `TMPC_CNT_ADDR: begin
          s_d.cnt = wdat[15:0];
          cnt_wr = 1'b1;
        end
        `TMPC_STS_ADDR: clr = wdat[3:0];
        `TMPC_MSK_ADDR: s_d.msk = wdat[3:0];
        `TMPC_FN_ADDR: s_d.fn_en = wdat[0];
        default: cnt_wr = 1'b0;
      endcase
    end
    s_d.sts = (s_q.sts & ~clr) | set;
    s_d.irq = |(s_d.sts & s_d.msk);
    // Bus read and address phase.
    case (s_q.addr)
      CTL0_ADDR: rval = {24'h0, s_q.ctl0};
      CTL1_ADDR: rval = {24'h0, s_q.ctl1};
      `TMPC_RELOAD_ADDR: rval = {16'h0, s_q.reload};
      `TMPC_CMP_ADDR: rval = {16'h0, s_q.cmp};
      `TMPC_CNT_ADDR: rval = {16'h0, s_q.cnt};
      `TMPC_CAP_ADDR: rval = {16'h0, s_q.cap};
      `TMPC_STS_ADDR: rval = {28'h0, s_q.sts};
      `TMPC_MSK_ADDR: rval = {28'h0, s_q.msk};
      `TMPC_FN_ADDR: rval = {31'h0, s_q.fn_en};
      default: rval = 32'h0;
    endcase
    s_d.wr_pend = 1'b0;
    s_d.rd_pend = 1'b0;
    s_d.ready = 1'b1;
    if (s_q.rd_pend) begin
      s_d.rdata = rval;
    end else if (HSEL && HTRANS[1] && HREADY) begin
      s_d.addr = HADDR;
      s_d.wr_pend = HWRITE;
      s_d.rd_pend = !HWRITE;
      s_d.ready = HWRITE;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  idle_hold_a: assert property (!en && !cnt_wr |=> $stable(s_q.cnt))
    else $error("Count moved while disabled.");
  idle_level_a: assert property (!en && mode != tmpc_pkg::PWM_DUAL |=> s_q.out == $past(pol))
    else $error("Disabled output not at polarity.");
  reload_tog_a: assert property (reload_ev && mode == tmpc_pkg::CONTINUOUS |=> s_q.out != $past(s_q.out))
    else $error("Output did not toggle on reload.");
  pwm_match_a: assert property (mode == tmpc_pkg::PWM_SINGLE && match_ev && !reload_ev
    |=> ##1 s_q.out == !$past(pol, 2))
    else $error("PWM output missed match level.");
  cap_edge_a: assert property (en && mode == tmpc_pkg::CAPTURE && sel_edge |=> s_q.cap == $past(s_q.cnt))
    else $error("Capture value wrong.");
  gate_stop_a: assert property (mode == tmpc_pkg::GATED && !(TIN ^ pol) && !cnt_wr |=> $stable(s_q.cnt))
    else $error("Gated count moved while inactive.");
  start_wait_a: assert property (mode == tmpc_pkg::CAPTURE_COMPARE && !s_q.started && !cnt_wr
    |=> $stable(s_q.cnt))
    else $error("Capture/compare counted before start.");
  dual_opp_a: assert property (mode == tmpc_pkg::PWM_DUAL && $past(mode) == tmpc_pkg::PWM_DUAL
    |-> s_q.out != s_q.outc || (s_q.out == $past(pol) && s_q.outc == $past(pol)))
    else $error("Dual outputs both active.");
  dead_band_a: assert property (mode == tmpc_pkg::PWM_DUAL && en && !settled |=> s_q.out == $past(pol))
    else $error("Output went active inside dead band.");
  irq_level_a: assert property (##1 IRQ == |(s_q.sts & s_q.msk))
    else $error("Interrupt level mismatch.");
endmodule // tmpc_top

// *** tmpc_pin_model.sv ***
// Purpose: Behavioural driver of the timer input pin.
// Assumes: Requests change just after a rising CLK edge.
// Notes: Between bursts the pin rests at the idle level.
`timescale 1ns/1ps
module tmpc_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requests
  input wire logic start,
  input wire logic idle,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half,
  // Pin
  output logic tin,
  output logic busy
);
  logic [8:0] left_q;
  logic [3:0] ph_q;
  assign busy = left_q != 9'h000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tin <= 1'b0;
      left_q <= 9'h000;
      ph_q <= 4'h0;
    end else if (start) begin
      left_q <= {pulses, 1'b0};
      ph_q <= 4'h0;
    end else if (left_q != 9'h000) begin
      if (ph_q == half) begin
        ph_q <= 4'h0;
        tin <= ~tin;
        left_q <= left_q - 9'h001;
      end else begin
        ph_q <= ph_q + 4'h1;
      end
    end else begin
      tin <= idle;
    end
  end
endmodule // tmpc_pin_model

// *** tb.sv ***
// Purpose: Self-checking bench of the timer control block.
// Assumes: One bus master; HREADY follows HREADYOUT.
// Notes: Pin stimulus comes from tmpc_pin_model.
`timescale 1ns/1ps
`include "tmpc_cfg.svh"
module tb;
  localparam logic [15:0] A_CTL0 = 16'h3C18;
  localparam logic [15:0] A_CTL1 = 16'h3C1C;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic [15:0] HADDR = 16'h0000;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h00000000;
  logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, TIN, TOUT, TOUT_OE, TOUTC, IRQ;
  logic start = 1'b0;
  logic idle = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic busy;
  int n_mismatch = 0;
  int checks = 0;
  logic [31:0] q;
  logic [31:0] c0;
  int w;
  int w0;
  logic [3:0] m;
  logic t;
  always #2.5 CLK = ~CLK;
  assign HREADY = HREADYOUT;
  tmpc_top dut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TIN(TIN), .TOUT(TOUT), .TOUT_OE(TOUT_OE), .TOUTC(TOUTC), .IRQ(IRQ));
  tmpc_pin_model pin (.clk(CLK), .rst_b(RST_B), .start(start), .idle(idle), .pulses(pulses),
    .half(4'h3), .tin(TIN), .busy(busy));
  // -----------------------------------------------------------------
  // Bus and check tasks
  // -----------------------------------------------------------------
  task automatic xfer(input logic [15:0] a, input logic wr_en, input logic [31:0] d, output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr_en;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    r = HRDATA;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h00000000, r);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tedge(output int n);
    logic v;
    v = TOUT;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (TOUT === v && n < 3000);
  endtask
  task automatic hiw(output int n);
    do tedge(n); while (TOUT !== 1'b1);
    tedge(n);
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(A_CTL1, q);
    chk(q, 32'h00000000);
    chk(32'(HRESP), 32'h0);
    rd(16'h0100, q);
    chk(q, 32'h00000000);
    wr(A_CTL1, 32'h0000003F);
    rd(A_CTL1, q);
    chk(q, 32'h0000003F);
    for (int i = 0; i < 14; i++) begin
      m = (i % 7 < 6) ? 4'((i % 7 == 2) ? 3 : (i % 7 == 3) ? 5 : (i % 7 == 4) ? 8 : (i % 7 == 5) ? 10 : i % 7) : 4'hB;
      wr(A_CTL0, {24'h0, m[3], 7'h00});
      wr(A_CTL1, {24'h0, 1'b0, 1'(i / 7), 3'h0, m[2:0]});
      repeat (3) @(posedge CLK);
      chk(32'(TOUT), 32'(i / 7));
      if (m == 4'h8) chk(32'(TOUTC), 32'(1 - i / 7));
    end
    wr(`TMPC_FN_ADDR, 32'h00000001);
    repeat (2) @(posedge CLK);
    chk(32'({TOUT_OE, TOUT}), 32'h3);
    wr(A_CTL0, 32'h00000000);
    wr(`TMPC_RELOAD_ADDR, 32'h00000004);
    for (int p = 0; p < 8; p++) begin
      wr(A_CTL1, 32'h81 | (p << 3));
      tedge(w);
      tedge(w);
      chk(32'(w), 32'(4 << p));
      wr(A_CTL1, 32'h00000001);
    end
    rd(`TMPC_STS_ADDR, q);
    chk(q & 32'h1, 32'h1);
    chk(32'(IRQ), 32'h0);
    wr(`TMPC_MSK_ADDR, 32'h00000001);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h1);
    wr(`TMPC_STS_ADDR, 32'h00000001);
    repeat (2) @(posedge CLK);
    chk(32'(IRQ), 32'h0);
    rd(`TMPC_CNT_ADDR, c0);
    repeat (10) @(posedge CLK);
    rd(`TMPC_CNT_ADDR, q);
    chk(q, c0);
    wr(`TMPC_RELOAD_ADDR, 32'h0000FFFF);
    wr(A_CTL1, 32'h00000081);
    t = TOUT;
    wr(A_CTL1, 32'h000000C1);
    repeat (3) @(posedge CLK);
    chk(32'(TOUT), 32'(t));
    for (int p = 0; p < 2; p++) begin
      idle <= 1'(p);
      wr(A_CTL1, 32'h00000002 | (p << 6));
      wr(A_CTL1, 32'h00000082 | (p << 6));
      rd(`TMPC_CNT_ADDR, c0);
      start <= 1'b1;
      pulses <= 8'h05;
      @(posedge CLK);
      start <= 1'b0;
      @(posedge CLK);
      while (busy === 1'b1) @(posedge CLK);
      repeat (4) @(posedge CLK);
      rd(`TMPC_CNT_ADDR, q);
      chk(q - c0, 32'h5);
    end
    for (int p = 0; p < 2; p++) begin
      wr(A_CTL1, 32'h00000084 | (p << 6));
      for (int e = 0; e < 2; e++) begin
        wr(`TMPC_STS_ADDR, 32'h0000000F);
        idle <= ~idle;
        repeat (4) @(posedge CLK);
        rd(`TMPC_STS_ADDR, q);
        chk(q[1], 1'(idle != p));
      end
    end
    idle <= 1'b0;
    wr(A_CTL1, 32'h00000086);
    rd(`TMPC_CNT_ADDR, c0);
    repeat (10) @(posedge CLK);
    rd(`TMPC_CNT_ADDR, q);
    chk(q, c0);
    idle <= 1'b1;
    wr(`TMPC_STS_ADDR, 32'h0000000F);
    idle <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(`TMPC_STS_ADDR, q);
    chk(q[3], 1'b1);
    wr(`TMPC_RELOAD_ADDR, 32'h00000040);
    wr(`TMPC_CMP_ADDR, 32'h00000010);
    wr(A_CTL0, 32'h00000080);
    wr(A_CTL1, 32'h00000080);
    hiw(w0);
    repeat (4) @(posedge CLK);
    chk(32'(TOUTC), 32'(!TOUT));
    for (int c = 1; c < 6; c += 2) begin
      wr(A_CTL0, 32'h80 | (c << 1));
      hiw(w);
      hiw(w);
      chk(32'(w0 - w), 32'(1 << c));
    end
    wr(A_CTL1, 32'h00000083);
    wr(A_CTL0, 32'h00000000);
    hiw(w);
    chk(32'(w), 32'd48);
    wr(A_CTL1, 32'h00000003);
    repeat (2) @(posedge CLK);
    chk(32'(TOUT), 32'h0);
    wr(A_CTL1, 32'h00000007);
    wr(A_CTL1, 32'h00000087);
    rd(`TMPC_CNT_ADDR, c0);
    repeat (10) @(posedge CLK);
    rd(`TMPC_CNT_ADDR, q);
    chk(q, c0);
    idle <= 1'b1;
    repeat (10) @(posedge CLK);
    rd(`TMPC_CNT_ADDR, q);
    chk(32'(q != c0), 32'h1);
    wr(`TMPC_STS_ADDR, 32'h0000000F);
    idle <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(`TMPC_STS_ADDR, q);
    chk(q[1], 1'b0);
    idle <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(`TMPC_STS_ADDR, q);
    chk(q[1], 1'b1);
    results();
  end
endmodule // tb
